// >>> shared/tcf_pkg.sv
// Constants and types shared by the timing and counting function blocks.
`default_nettype none
package tcf_pkg;
  // Clock and time base.
  localparam int TCF_CLK_PERIOD_NS  = 10;
  localparam int TCF_TICK_PERIOD_MS = 10;
  localparam int TCF_TICK_CYCLES    = TCF_TICK_PERIOD_MS * 1000000 / TCF_CLK_PERIOD_NS;

  // Field widths.
  localparam int TCF_PERIOD_W = 14;
  localparam int TCF_UNIT_W   = 2;
  localparam int TCF_COUNT_W  = 24;
  localparam int TCF_SUB_W    = 12;
  localparam int TCF_ADDR_W   = 8;

  // Time settings in hundredths of the selected unit, then counter limits.
  localparam logic [13:0] TCF_PERIOD_MIN = 14'h0001;
  localparam logic [13:0] TCF_PERIOD_MAX = 14'h270F;
  localparam logic [13:0] TCF_PERIOD_DEF = 14'h0064;
  localparam logic [23:0] TCF_COUNT_MAX  = 24'h98967F;
  localparam logic [23:0] TCF_COUNT_ZERO = 24'h000000;
  localparam logic [23:0] TCF_COUNT_ONE  = 24'h000001;

  // Unit codes and the last sub-tick index of one hundredth of each unit.
  localparam logic [1:0]  TCF_UNIT_SEC      = 2'h0;
  localparam logic [1:0]  TCF_UNIT_MIN      = 2'h1;
  localparam logic [1:0]  TCF_UNIT_HOUR     = 2'h2;
  localparam logic [11:0] TCF_SUB_LAST_SEC  = 12'h000;
  localparam logic [11:0] TCF_SUB_LAST_MIN  = 12'h03B;
  localparam logic [11:0] TCF_SUB_LAST_HOUR = 12'hE0F;

  // Register field positions.
  localparam int TCF_CFG_PERIOD_LSB = 0;
  localparam int TCF_CFG_UNIT_LSB   = 16;
  localparam int TCF_ST_SQW         = 0;
  localparam int TCF_ST_DLY         = 1;
  localparam int TCF_ST_UP          = 2;
  localparam int TCF_ST_DN          = 3;

  // Register byte offsets.
  localparam logic [7:0] TCF_OFF_SQW_CFG = 8'h00;
  localparam logic [7:0] TCF_OFF_DLY_CFG = 8'h04;
  localparam logic [7:0] TCF_OFF_UP_THR  = 8'h08;
  localparam logic [7:0] TCF_OFF_DN_PRE  = 8'h0C;
  localparam logic [7:0] TCF_OFF_STATUS  = 8'h10;
  localparam logic [7:0] TCF_OFF_UP_CNT  = 8'h14;
  localparam logic [7:0] TCF_OFF_DN_CNT  = 8'h18;

  localparam logic [1:0] TCF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TCF_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SQW_OFF, SQW_LOW, SQW_HIGH} tcf_sqw_state_t;
  typedef enum logic [1:0] {DLY_IDLE, DLY_TIMING, DLY_DONE} tcf_dly_state_t;
endpackage
`default_nettype wire

// >>> hw/tcf_interval_timer.sv
// Interval timer that counts hundredths of a selectable time unit.
`timescale 1ns/10ps
`default_nettype none
module tcf_interval_timer
#(
  parameter int PERIOD_W = tcf_pkg::TCF_PERIOD_W
)
(
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic                          tick_en,
  input  wire logic                          start,
  input  wire logic                          run,
  input  wire logic [PERIOD_W-1:0]           period,
  input  wire logic [tcf_pkg::TCF_UNIT_W-1:0] unit,
  output logic                               expire
);
  import tcf_pkg::*;

  logic [TCF_SUB_W-1:0] sub_ff;
  logic [PERIOD_W-1:0]  hund_ff;
  logic                 expire_ff;
  logic                 clear;
  logic                 sub_last;
  logic                 hund_last;

  function automatic logic [TCF_SUB_W-1:0] sub_last_of(input logic [TCF_UNIT_W-1:0] u);
    case (u)
      TCF_UNIT_MIN:  sub_last_of = TCF_SUB_LAST_MIN;
      TCF_UNIT_HOUR: sub_last_of = TCF_SUB_LAST_HOUR;
      default:       sub_last_of = TCF_SUB_LAST_SEC;
    endcase
  endfunction

  assign clear     = sys_rst | start | ~run;
  assign sub_last  = (sub_ff == sub_last_of(unit));
  assign hund_last = (hund_ff == period - PERIOD_W'(1));
  assign expire    = expire_ff;

  // Counters restart at zero on start, so timing begins at the next tick.
  always_ff @(posedge clk_sys)
  begin
    if (clear)
    begin
      sub_ff  <= '0;
      hund_ff <= '0;
    end
    else if (tick_en)
    begin
      if (sub_last)
      begin
        sub_ff  <= '0;
        hund_ff <= hund_last ? '0 : hund_ff + PERIOD_W'(1);
      end
      else
      begin
        sub_ff <= sub_ff + TCF_SUB_W'(1);
      end
    end
  end

  // Counters reload as they wrap, so a running timer repeats without gaps.
  always_ff @(posedge clk_sys)
  begin
    expire_ff <= ~clear & tick_en & sub_last & hund_last;
  end
endmodule
`default_nettype wire

// >>> hw/tcf_timer_blocks.sv
// Square-wave source, retentive on-delay, up and down counters with AXI4-Lite.
// Summary of operation
// - Square wave starts timing on enable rise, output goes high after period.
// - While enabled, output toggles at each expiry with equal high and low times.
// - Enable low stops the square wave and holds its output low.
// - Square-wave reset high forces its output low whatever enable does.
// - Reset falling with enable high restarts from low, full period first.
// - Square-wave period is 0.01 to 99.99 in seconds, minutes or hours.
// - Square-wave timing error stays within half a second.
// - On-delay starts timing on trigger rise, output goes high after delay.
// - On-delay output stays high, ignoring triggers, until reset.
// - On-delay reset clears time and output and beats the trigger.
// - On-delay setting is 0.01 to 99.99 in seconds, minutes or hours.
// - Up counter reset wins; clears count and output while asserted.
// - Up counter adds one per count rising edge up to 9999999, ignoring other activity.
// - Up output is high while count reaches threshold; threshold 0 to 9999999.
// - Down counter reset wins; sets count to zero and clears output.
// - Down counter subtracts one per count rising edge, stopping at zero.
// - Down output goes high when decremented to zero; preset 0 to 9999999.
`timescale 1ns/10ps
`default_nettype none
module tcf_timer_blocks
#(
  parameter int TICK_CYCLES = tcf_pkg::TCF_TICK_CYCLES
)
(
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [tcf_pkg::TCF_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [tcf_pkg::TCF_ADDR_W-1:0] s_axi_araddr,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  input  wire logic                          sqw_enable,
  input  wire logic                          sqw_reset,
  output logic                               sqw_out,
  input  wire logic                          dly_trigger_input,
  input  wire logic                          dly_reset,
  output logic                               dly_out,
  input  wire logic                          up_count_pulse_input,
  input  wire logic                          up_reset,
  output logic                               up_out,
  input  wire logic                          dn_count_pulse_input,
  input  wire logic                          dn_reset,
  output logic                               dn_out
);
  import tcf_pkg::*;

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [TICK_W-1:0]      tick_cnt_ff;
  logic                   tick_ff;
  logic                   aw_held_ff;
  logic                   w_held_ff;
  logic [TCF_ADDR_W-1:0]  awaddr_ff;
  logic [31:0]            wdata_ff;
  logic [3:0]             wstrb_ff;
  logic                   awready_ff;
  logic                   wready_ff;
  logic                   bvalid_ff;
  logic [1:0]             bresp_ff;
  logic                   arready_ff;
  logic                   rvalid_ff;
  logic [31:0]            rdata_ff;
  logic [1:0]             rresp_ff;
  logic [TCF_PERIOD_W-1:0] sqw_period_ff;
  logic [TCF_UNIT_W-1:0]  sqw_unit_ff;
  logic [TCF_PERIOD_W-1:0] dly_period_ff;
  logic [TCF_UNIT_W-1:0]  dly_unit_ff;
  logic [TCF_COUNT_W-1:0] up_thr_ff;
  logic [TCF_COUNT_W-1:0] dn_pre_ff;
  logic [TCF_COUNT_W-1:0] up_cnt_ff;
  logic [TCF_COUNT_W-1:0] nxt_up_cnt;
  logic [TCF_COUNT_W-1:0] dn_cnt_ff;
  logic [TCF_COUNT_W-1:0] nxt_dn_cnt;
  logic                   up_q_ff;
  logic                   dn_q_ff;
  logic                   sqw_q_ff;
  logic                   dly_q_ff;
  tcf_sqw_state_t         sqw_state_ff;
  tcf_dly_state_t         dly_state_ff;
  logic                   sqw_active_prev_ff;
  logic                   trig_prev_ff;
  logic                   up_prev_ff;
  logic                   dn_prev_ff;
  logic                   do_write;
  logic [31:0]            wr_word;
  logic                   dn_load;
  logic                   sqw_active;
  logic                   sqw_start;
  logic                   sqw_expire;
  logic                   dly_start;
  logic                   dly_expire;
  logic                   trig_rise;
  logic                   up_rise;
  logic                   dn_rise;

  function automatic logic [TCF_PERIOD_W-1:0] clamp_period(input logic [TCF_PERIOD_W-1:0] p);
    if (p < TCF_PERIOD_MIN)
      clamp_period = TCF_PERIOD_MIN;
    else if (p > TCF_PERIOD_MAX)
      clamp_period = TCF_PERIOD_MAX;
    else
      clamp_period = p;
  endfunction

  function automatic logic [TCF_COUNT_W-1:0] clamp_count(input logic [TCF_COUNT_W-1:0] c);
    clamp_count = (c > TCF_COUNT_MAX) ? TCF_COUNT_MAX : c;
  endfunction

  function automatic logic [31:0] cfg_word(input logic [TCF_PERIOD_W-1:0] p,
                                           input logic [TCF_UNIT_W-1:0]   u);
    cfg_word = '0;
    cfg_word[TCF_CFG_PERIOD_LSB +: TCF_PERIOD_W] = p;
    cfg_word[TCF_CFG_UNIT_LSB +: TCF_UNIT_W]     = u;
  endfunction

  function automatic logic [TCF_ADDR_W-1:0] aligned(input logic [TCF_ADDR_W-1:0] a);
    aligned = {a[TCF_ADDR_W-1:2], 2'h0};
  endfunction

  function automatic logic writable(input logic [TCF_ADDR_W-1:0] a);
    case (aligned(a))
      TCF_OFF_SQW_CFG, TCF_OFF_DLY_CFG, TCF_OFF_UP_THR, TCF_OFF_DN_PRE: writable = 1'b1;
      default: writable = 1'b0;
    endcase
  endfunction

  function automatic logic readable(input logic [TCF_ADDR_W-1:0] a);
    case (aligned(a))
      TCF_OFF_STATUS, TCF_OFF_UP_CNT, TCF_OFF_DN_CNT: readable = 1'b1;
      default: readable = writable(a);
    endcase
  endfunction

  function automatic logic [31:0] reg_word(input logic [TCF_ADDR_W-1:0] a);
    reg_word = '0;
    case (aligned(a))
      TCF_OFF_SQW_CFG: reg_word = cfg_word(sqw_period_ff, sqw_unit_ff);
      TCF_OFF_DLY_CFG: reg_word = cfg_word(dly_period_ff, dly_unit_ff);
      TCF_OFF_UP_THR:  reg_word[TCF_COUNT_W-1:0] = up_thr_ff;
      TCF_OFF_DN_PRE:  reg_word[TCF_COUNT_W-1:0] = dn_pre_ff;
      TCF_OFF_UP_CNT:  reg_word[TCF_COUNT_W-1:0] = up_cnt_ff;
      TCF_OFF_DN_CNT:  reg_word[TCF_COUNT_W-1:0] = dn_cnt_ff;
      TCF_OFF_STATUS:
      begin
        reg_word[TCF_ST_SQW] = sqw_q_ff;
        reg_word[TCF_ST_DLY] = dly_q_ff;
        reg_word[TCF_ST_UP]  = up_q_ff;
        reg_word[TCF_ST_DN]  = dn_q_ff;
      end
      default: reg_word = '0;
    endcase
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    apply_strb = res;
  endfunction

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign sqw_out       = sqw_q_ff;
  assign dly_out       = dly_q_ff;
  assign up_out        = up_q_ff;
  assign dn_out        = dn_q_ff;

  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_word  = apply_strb(reg_word(awaddr_ff), wdata_ff, wstrb_ff);
  assign dn_load  = do_write & (aligned(awaddr_ff) == TCF_OFF_DN_PRE);

  // Ten millisecond time base; tick alignment costs at most one tick of error.
  // Shared time base
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || tick_cnt_ff == TICK_W'(TICK_CYCLES - 1))
      tick_cnt_ff <= '0;
    else
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
    tick_ff <= ~sys_rst & (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
  end

  // Write address and data are taken independently and held until the write.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      awaddr_ff  <= '0;
    end
    else if (s_axi_awvalid && awready_ff)
    begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff  <= s_axi_awaddr;
    end
    else
    begin
      if (do_write)
        aw_held_ff <= 1'b0;
      awready_ff <= ~aw_held_ff;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end
    else if (s_axi_wvalid && wready_ff)
    begin
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end
    else
    begin
      if (do_write)
        w_held_ff <= 1'b0;
      wready_ff <= ~w_held_ff;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= TCF_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= writable(awaddr_ff) ? TCF_RESP_OKAY : TCF_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= TCF_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= reg_word(s_axi_araddr);
      rresp_ff   <= readable(s_axi_araddr) ? TCF_RESP_OKAY : TCF_RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
    else if (!rvalid_ff)
    begin
      arready_ff <= 1'b1;
    end
  end

  // Periods and counts are clamped into their legal ranges as they are written.
  // Time setting ranges
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sqw_period_ff <= TCF_PERIOD_DEF;
      sqw_unit_ff   <= TCF_UNIT_SEC;
      dly_period_ff <= TCF_PERIOD_DEF;
      dly_unit_ff   <= TCF_UNIT_SEC;
      up_thr_ff     <= TCF_COUNT_ZERO;
      dn_pre_ff     <= TCF_COUNT_ZERO;
    end
    else if (do_write)
    begin
      case (aligned(awaddr_ff))
        TCF_OFF_SQW_CFG:
        begin
          sqw_period_ff <= clamp_period(wr_word[TCF_CFG_PERIOD_LSB +: TCF_PERIOD_W]);
          sqw_unit_ff   <= wr_word[TCF_CFG_UNIT_LSB +: TCF_UNIT_W];
        end
        TCF_OFF_DLY_CFG:
        begin
          dly_period_ff <= clamp_period(wr_word[TCF_CFG_PERIOD_LSB +: TCF_PERIOD_W]);
          dly_unit_ff   <= wr_word[TCF_CFG_UNIT_LSB +: TCF_UNIT_W];
        end
        TCF_OFF_UP_THR: up_thr_ff <= clamp_count(wr_word[TCF_COUNT_W-1:0]);
        TCF_OFF_DN_PRE: dn_pre_ff <= clamp_count(wr_word[TCF_COUNT_W-1:0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    sqw_active_prev_ff <= ~sys_rst & sqw_active;
    trig_prev_ff       <= ~sys_rst & dly_trigger_input;
    up_prev_ff         <= ~sys_rst & up_count_pulse_input;
    dn_prev_ff         <= ~sys_rst & dn_count_pulse_input;
  end

  assign sqw_active = sqw_enable & ~sqw_reset;
  // Start on enable rise or reset release
  assign sqw_start  = sqw_active & ~sqw_active_prev_ff;
  assign trig_rise  = dly_trigger_input & ~trig_prev_ff;
  assign up_rise    = up_count_pulse_input & ~up_prev_ff;
  assign dn_rise    = dn_count_pulse_input & ~dn_prev_ff;
  // Only an idle timer accepts a trigger
  assign dly_start  = (dly_state_ff == DLY_IDLE) & trig_rise & ~dly_reset;

  tcf_interval_timer #(
    .PERIOD_W (TCF_PERIOD_W)
  ) u_sqw_timer (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_en  (tick_ff),
    .start    (sqw_start),
    .run      (sqw_active),
    .period   (sqw_period_ff),
    .unit     (sqw_unit_ff),
    .expire   (sqw_expire)
  );

  tcf_interval_timer #(
    .PERIOD_W (TCF_PERIOD_W)
  ) u_dly_timer (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_en  (tick_ff),
    .start    (dly_start),
    .run      (dly_state_ff == DLY_TIMING),
    .period   (dly_period_ff),
    .unit     (dly_unit_ff),
    .expire   (dly_expire)
  );

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !sqw_active)
    begin
      sqw_state_ff <= SQW_OFF;
      sqw_q_ff     <= 1'b0;
    end
    else if (sqw_start)
    begin
      sqw_state_ff <= SQW_LOW;
      sqw_q_ff     <= 1'b0;
    end
    else if (sqw_expire)
    begin
      case (sqw_state_ff)
        SQW_LOW:
        begin
          sqw_state_ff <= SQW_HIGH;
          sqw_q_ff     <= 1'b1;
        end
        SQW_HIGH:
        begin
          sqw_state_ff <= SQW_LOW;
          sqw_q_ff     <= 1'b0;
        end
        default:
        begin
          sqw_state_ff <= SQW_OFF;
          sqw_q_ff     <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || dly_reset)
    begin
      dly_state_ff <= DLY_IDLE;
      dly_q_ff     <= 1'b0;
    end
    else
    begin
      case (dly_state_ff)
        DLY_IDLE:
          if (dly_start)
            dly_state_ff <= DLY_TIMING;
        DLY_TIMING:
          if (dly_expire)
          begin
            dly_state_ff <= DLY_DONE;
            dly_q_ff     <= 1'b1;
          end
        DLY_DONE:
          dly_q_ff <= 1'b1;
        default:
        begin
          dly_state_ff <= DLY_IDLE;
          dly_q_ff     <= 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    nxt_up_cnt = up_cnt_ff;
    if (up_reset)
      nxt_up_cnt = TCF_COUNT_ZERO;
    else if (up_rise && up_cnt_ff != TCF_COUNT_MAX)
      nxt_up_cnt = up_cnt_ff + TCF_COUNT_ONE;
  end

  always_comb
  begin
    nxt_dn_cnt = dn_cnt_ff;
    if (dn_reset)
      nxt_dn_cnt = TCF_COUNT_ZERO;
    else if (dn_load)
      nxt_dn_cnt = clamp_count(wr_word[TCF_COUNT_W-1:0]);
    else if (dn_rise && dn_cnt_ff != TCF_COUNT_ZERO)
      nxt_dn_cnt = dn_cnt_ff - TCF_COUNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      up_cnt_ff <= TCF_COUNT_ZERO;
      up_q_ff   <= 1'b0;
    end
    else
    begin
      up_cnt_ff <= nxt_up_cnt;
      up_q_ff   <= ~up_reset & (nxt_up_cnt >= up_thr_ff);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || dn_reset || dn_load)
    begin
      dn_q_ff <= 1'b0;
    end
    else if (dn_rise && dn_cnt_ff == TCF_COUNT_ONE)
    begin
      dn_q_ff <= 1'b1;
    end
    if (sys_rst)
      dn_cnt_ff <= TCF_COUNT_ZERO;
    else
      dn_cnt_ff <= nxt_dn_cnt;
  end
endmodule
`default_nettype wire

// >>> testbench/tcf_timer_blocks_sva.sv
// Port-level assertions for the timing and counting function blocks.
`timescale 1ns/10ps
`default_nettype none
module tcf_timer_blocks_sva
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sqw_enable,
  input wire logic sqw_reset,
  input wire logic sqw_out,
  input wire logic dly_reset,
  input wire logic dly_out,
  input wire logic up_reset,
  input wire logic up_out,
  input wire logic dn_count_pulse_input,
  input wire logic dn_reset,
  input wire logic dn_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_SQW_START: assert property ($rose(sqw_out) |->
    $past(sqw_enable) && $past(sqw_enable, 2) && !$past(sqw_reset))
    else $error("square wave rose without a running enable");
  AST_SQW_OFF: assert property (!sqw_enable |=> !sqw_out)
    else $error("square wave high with enable low");
  AST_SQW_RESET: assert property (sqw_reset |=> !sqw_out)
    else $error("square wave high during its reset");
  AST_DLY_HOLD: assert property (dly_out && !dly_reset |=> dly_out)
    else $error("on-delay output dropped without reset");
  AST_DLY_RESET: assert property (dly_reset |=> !dly_out)
    else $error("on-delay output high during reset");
  AST_UP_RESET: assert property (up_reset |=> !up_out)
    else $error("up counter output high during reset");
  AST_DN_RESET: assert property (dn_reset |=> !dn_out)
    else $error("down counter output high during reset");
  AST_DN_ZERO: assert property ($rose(dn_out) |->
    $past(dn_count_pulse_input) && !$past(dn_count_pulse_input, 2) && !$past(dn_reset))
    else $error("down counter output rose without a count edge");
  cover property ($rose(sqw_out));
  cover property ($rose(dly_out));
  cover property ($rose(dn_out));
endmodule
bind tcf_timer_blocks tcf_timer_blocks_sva u_sva (.clk_sys, .sys_rst, .sqw_enable, .sqw_reset,
  .sqw_out, .dly_reset, .dly_out, .up_reset, .up_out, .dn_count_pulse_input, .dn_reset, .dn_out);
`default_nettype wire

// >>> testbench/tcf_pulse_src.sv
// Neighbouring logic block that answers a request with a three-cycle high pulse.
`timescale 1ns/10ps
`default_nettype none
module tcf_pulse_src
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic fire,
  output logic      pulse_out
);
  logic [1:0] left_ff;
  // Several cycles high so that a level held high must not count twice.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      left_ff <= 2'h0;
    else if (fire)
      left_ff <= 2'h3;
    else if (left_ff != 2'h0)
      left_ff <= left_ff - 2'h1;
  end
  assign pulse_out = (left_ff != 2'h0);
endmodule
`default_nettype wire

// >>> testbench/tcf_timer_blocks_tb_top.sv
// Self-checking bench for the timing and counting function blocks.
`timescale 1ns/10ps
`default_nettype none
module tcf_timer_blocks_tb_top;
  import tcf_pkg::*;
  logic clk_sys, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic sqw_enable, sqw_reset, sqw_out, dly_trigger_input, dly_reset, dly_out;
  logic up_count_pulse_input, up_reset, up_out, dn_count_pulse_input, dn_reset, dn_out;
  logic [2:0] fire;
  int err_count, num_checks, n, h;
  tcf_timer_blocks #(.TICK_CYCLES(4)) DUT (.*);
  tcf_pulse_src u_up (.clk_sys, .sys_rst, .fire(fire[0]), .pulse_out(up_count_pulse_input));
  tcf_pulse_src u_dn (.clk_sys, .sys_rst, .fire(fire[1]), .pulse_out(dn_count_pulse_input));
  tcf_pulse_src u_tr (.clk_sys, .sys_rst, .fire(fire[2]), .pulse_out(dly_trigger_input));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready === 1'b1) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w && s_axi_wready === 1'b1) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never re-raises bready in the same step.
    @(posedge clk_sys);
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic kick(input int k);
    fire[k] <= 1'b1;
    @(posedge clk_sys);
    fire[k] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic span(input logic lv, output int c);
    c = 0;
    while (sqw_out === lv && c < 60) begin @(posedge clk_sys); c++; end
  endtask
  task automatic test_regs;
    rdr(TCF_OFF_SQW_CFG);
    chk("sqw_cfg_reset", 32'h00000064, rd);
    rdr(8'h1C);
    chk("unmapped_data", 32'h00000000, rd);
    chk("unmapped_resp", {30'h0, TCF_RESP_SLVERR}, {30'h0, rs});
    wr(TCF_OFF_STATUS, 32'h0000000F);
    chk("ro_write_resp", {30'h0, TCF_RESP_SLVERR}, {30'h0, rs});
    $display("test_regs finished");
  endtask
  task automatic test_sqw;
    wr(TCF_OFF_SQW_CFG, 32'h00000002);
    sqw_enable <= 1'b1;
    span(1'b0, n);
    chk("sqw_first_ok", 1, n >= 8 && n <= 14);
    span(1'b1, h);
    span(1'b0, n);
    chk("sqw_low_time", h, n);
    chk("sqw_high_ok", 1, h >= 8 && h <= 12);
    sqw_reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("sqw_in_reset", 0, sqw_out);
    sqw_reset <= 1'b0;
    span(1'b0, n);
    chk("sqw_restart_ok", 1, n >= 8 && n <= 14);
    sqw_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("sqw_disabled", 0, sqw_out);
    $display("test_sqw finished");
  endtask
  task automatic test_dly;
    wr(TCF_OFF_DLY_CFG, 32'h00000004);
    kick(2);
    kick(2);
    n = 14;
    while (dly_out !== 1'b1 && n < 60) begin @(posedge clk_sys); n++; end
    chk("dly_time_ok", 1, n >= 16 && n <= 21);
    kick(2);
    chk("dly_held", 1, dly_out);
    fire[2] <= 1'b1; dly_reset <= 1'b1;
    @(posedge clk_sys);
    fire[2] <= 1'b0;
    repeat (7) @(posedge clk_sys);
    dly_reset <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("dly_cleared", 0, dly_out);
    $display("test_dly finished");
  endtask
  task automatic test_counters;
    wr(TCF_OFF_UP_THR, 32'h00000003);
    wr(TCF_OFF_DN_PRE, 32'h00000002);
    kick(0); kick(0); kick(1);
    chk("up_below", 0, up_out);
    rdr(TCF_OFF_UP_CNT);
    chk("up_count", 32'h00000002, rd);
    rdr(TCF_OFF_DN_CNT);
    chk("dn_count", 32'h00000001, rd);
    chk("dn_not_zero", 0, dn_out);
    kick(0); kick(1); kick(1);
    chk("up_reached", 1, up_out);
    chk("dn_zero", 1, dn_out);
    rdr(TCF_OFF_DN_CNT);
    chk("dn_floor", 32'h00000000, rd);
    up_reset <= 1'b1; dn_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    up_reset <= 1'b0; dn_reset <= 1'b0;
    @(posedge clk_sys);
    chk("up_cleared", 0, up_out);
    chk("dn_cleared", 0, dn_out);
    rdr(TCF_OFF_UP_CNT);
    chk("up_count_clr", 32'h00000000, rd);
    $display("test_counters finished");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    sys_rst = 1'b1; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF; sqw_enable = 1'b0; sqw_reset = 1'b0;
    dly_reset = 1'b0; up_reset = 1'b0; dn_reset = 1'b0; fire = 3'h0;
    err_count = 0; num_checks = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    test_regs();
    test_sqw();
    test_dly();
    test_counters();
    tally_and_finish();
  end
endmodule
`default_nettype wire
